// file: rtl/spw_defs.svh
`ifndef SPW_DEFS_SVH
`define SPW_DEFS_SVH
// Word widths.
`define SPW_WORD_W       10
`define SPW_BYTE_W       8
// Field positions in the parallel words.
`define SPW_CTRL_BIT     8
`define SPW_VIOL_BIT     9
// System clock divider: half period in sys clocks (parameter default).
`define SPW_SYSCLK_HALF  2
// Serial line rates in kbps and bits per word.
`define SPW_RATE_FULL_KBPS 1228800
`define SPW_RATE_HALF_KBPS 614400
`define SPW_BITS_PER_WORD  10
`endif

// file: rtl/spw_pkg.sv
package spw_pkg;
    // Word mode of the parallel port.
    typedef enum logic [1:0] {
        SPW_MODE_TEN   = 2'b01,
        SPW_MODE_EIGHT = 2'b10
    } spw_mode_t;
    // Direction of the receive word clock pin.
    typedef enum logic [1:0] {
        SPW_RX_WORD_CLOCK_WRITE = 2'b01,
        SPW_RX_WORD_CLOCK_READ  = 2'b10
    } spw_rxdir_t;
endpackage : spw_pkg

// file: rtl/spw_codec_8b10b.sv
`timescale 1ns/1ps
// Combinational 8b/10b encoder and decoder with running disparity input.
module spw_codec_8b10b (
    // Encoder side.
    input  wire logic [7:0] enc_byte_in,
    input  wire logic       enc_ctrl_in,
    input  wire logic       enc_rd_in,
    output logic      [9:0] enc_code_out,
    output logic            enc_rd_out,
    // Decoder side.
    input  wire logic [9:0] dec_code_in,
    output logic      [7:0] dec_byte_out,
    output logic            dec_ctrl_out,
    output logic            dec_viol_out
);
    // Count of ones in a code group.
    function automatic logic [3:0] spw_ones(input logic [9:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 10; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction : spw_ones

    // Encode one byte at the given disparity (false = negative).
    function automatic logic [9:0] spw_enc(input logic [7:0] b, input logic k, input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic [4:0] x;
        logic [2:0] y;
        logic       rd6;
        x = b[4:0];
        y = b[7:5];
        // Five-to-six table for negative disparity, flipped when needed.
        unique case (x)
            5'h00: s6 = 6'h27; 5'h01: s6 = 6'h1D; 5'h02: s6 = 6'h2D; 5'h03: s6 = 6'h31;
            5'h04: s6 = 6'h35; 5'h05: s6 = 6'h29; 5'h06: s6 = 6'h19; 5'h07: s6 = 6'h38;
            5'h08: s6 = 6'h39; 5'h09: s6 = 6'h25; 5'h0A: s6 = 6'h15; 5'h0B: s6 = 6'h34;
            5'h0C: s6 = 6'h0D; 5'h0D: s6 = 6'h2C; 5'h0E: s6 = 6'h1C; 5'h0F: s6 = 6'h17;
            5'h10: s6 = 6'h1B; 5'h11: s6 = 6'h23; 5'h12: s6 = 6'h13; 5'h13: s6 = 6'h32;
            5'h14: s6 = 6'h0B; 5'h15: s6 = 6'h2A; 5'h16: s6 = 6'h1A; 5'h17: s6 = 6'h3A;
            5'h18: s6 = 6'h33; 5'h19: s6 = 6'h26; 5'h1A: s6 = 6'h16; 5'h1B: s6 = 6'h36;
            5'h1C: s6 = 6'h0E; 5'h1D: s6 = 6'h2E; 5'h1E: s6 = 6'h1E; default: s6 = 6'h2B;
        endcase
        if (k && x == 5'h1C) begin
            s6 = 6'h0F;
        end
        // Unbalanced groups and D.07 flip with positive disparity.
        if (rd && (s6 != 6'h38 || x == 5'h07) && (spw_ones({4'h0, s6}) != 4'h3 || x == 5'h07)) begin
            s6 = ~s6;
        end
        rd6 = (spw_ones({4'h0, s6}) == 4'h3) ? rd : ~rd;
        unique case (y)
            3'h0: s4 = 4'hB; 3'h1: s4 = 4'h9; 3'h2: s4 = 4'h5; 3'h3: s4 = 4'hC;
            3'h4: s4 = 4'hD; 3'h5: s4 = 4'hA; 3'h6: s4 = 4'h6; default: s4 = 4'hE;
        endcase
        if (y == 3'h7 && (k || (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
                             || (rd6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)))) begin
            s4 = 4'h7;
        end
        if (k && rd6 == 1'b0 && (y == 3'h1 || y == 3'h2 || y == 3'h5 || y == 3'h6)) begin
            s4 = ~s4;
        end
        if (rd6 && (spw_ones({6'h0, s4}) != 4'h2 || y == 3'h3)) begin
            s4 = ~s4;
        end
        return {s6, s4};
    endfunction : spw_enc

    // Encoder outputs and running disparity after the group.
    assign enc_code_out = spw_enc(enc_byte_in, enc_ctrl_in, enc_rd_in);
    assign enc_rd_out   = (spw_ones(enc_code_out) == 4'h5) ? enc_rd_in : ~enc_rd_in;

    // Decoder: search every data byte and six control characters at both disparities.
    always_comb begin
        logic hit;
        hit          = 1'b0;
        dec_byte_out = 8'h00;
        dec_ctrl_out = 1'b0;
        for (int c = 0; c < 1024; c++) begin
            if (!hit && (spw_enc(c[7:0], c[8], c[9]) == dec_code_in)
                && (!c[8] || c[7:0] == 8'hBC || c[7:0] == 8'h1C || c[7:0] == 8'hFB
                    || c[7:0] == 8'hFD || c[7:0] == 8'hFE || c[7:0] == 8'hF7)) begin
                hit          = 1'b1;
                dec_byte_out = c[7:0];
                dec_ctrl_out = c[8];
            end
        end
        dec_viol_out = ~hit;
    end
endmodule : spw_codec_8b10b

// file: rtl/spw_word_port.sv
`timescale 1ns/1ps
`include "spw_defs.svh"
// Parallel word side of the serializer/deserializer.
module spw_word_port #(
    parameter int SYSCLK_HALF = `SPW_SYSCLK_HALF
) (
    // Clock and reset.
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // Static configuration.
    input  wire logic        eight_bit_mode_in,
    input  wire logic        rx_clock_direction_select_in,
    input  wire logic        operating_select_in,
    input  wire logic        link_idle_in,
    // Transmit side.
    input  wire logic        tx_word_clock_in,
    input  wire logic [9:0]  tx_word_in,
    output logic      [9:0]  tx_serial_word_out,
    output logic             tx_serial_valid_out,
    // Receive side from the deserializer.
    input  wire logic [9:0]  rx_code_in,
    input  wire logic        rx_code_valid_in,
    input  wire logic        rx_pll_locked_in,
    input  wire logic        rx_signal_present_in,
    input  wire logic        rx_word_clock_in,
    output logic             rx_word_clock_out,
    output logic             rx_word_clock_oe_out,
    output logic      [9:0]  rx_parallel_word_out,
    // Status.
    output logic             signal_loss_flag_out,
    output logic             rx_pll_unlocked_n_out,
    output logic             code_violation_flag_out,
    output logic             system_clock_out_pos,
    output logic             system_clock_out_neg
);
    // Latched modes.
    spw_pkg::spw_mode_t  mode_q;
    spw_pkg::spw_rxdir_t rxdir_q;
    // Synchronisers for pins.
    logic [1:0] txc_s_q, rxc_s_q;
    logic       txc_prev_q, rxc_prev_q;
    // Running disparity and recovered clock toggle.
    logic       rd_q, rec_clk_q;
    logic [9:0] rx_hold_q;
    // Divider for the system clock.
    logic [7:0] div_q;
    logic       sysclk_q;
    // Codec nets.
    logic [9:0] enc_code;
    logic       enc_rd;
    logic [7:0] dec_byte;
    logic       dec_ctrl, dec_viol;

    // Edge detection on synchronised clocks.
    wire eight      = (mode_q == spw_pkg::SPW_MODE_EIGHT);
    wire read_mode  = (rxdir_q == spw_pkg::SPW_RX_WORD_CLOCK_READ);
    wire tx_rise    = txc_s_q[1] & ~txc_prev_q;
    wire rxc_edge   = rxc_s_q[1] ^ rxc_prev_q;
    wire rx_launch  = read_mode ? rxc_edge : rx_code_valid_in;
    wire [9:0] rx_eight = {dec_viol, dec_ctrl, dec_byte};
    wire [9:0] rx_sel   = eight ? rx_eight : rx_hold_q;

    spw_codec_8b10b u_codec (
        .enc_byte_in  (tx_word_in[7:0]),
        .enc_ctrl_in  (tx_word_in[`SPW_CTRL_BIT]),
        .enc_rd_in    (rd_q),
        .enc_code_out (enc_code),
        .enc_rd_out   (enc_rd),
        .dec_code_in  (rx_hold_q),
        .dec_byte_out (dec_byte),
        .dec_ctrl_out (dec_ctrl),
        .dec_viol_out (dec_viol)
    );

    // Mode latch: taken only while the link is idle.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mode_q  <= spw_pkg::SPW_MODE_TEN;
            rxdir_q <= spw_pkg::SPW_RX_WORD_CLOCK_WRITE;
        end else if (link_idle_in) begin
            mode_q  <= eight_bit_mode_in ? spw_pkg::SPW_MODE_EIGHT : spw_pkg::SPW_MODE_TEN;
            rxdir_q <= rx_clock_direction_select_in ? spw_pkg::SPW_RX_WORD_CLOCK_READ : spw_pkg::SPW_RX_WORD_CLOCK_WRITE;
        end
    end

    // Two-flop synchronisers and previous values for edge finding.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            txc_s_q    <= 2'h0;
            rxc_s_q    <= 2'h0;
            txc_prev_q <= 1'b0;
            rxc_prev_q <= 1'b0;
        end else begin
            txc_s_q    <= {txc_s_q[0], tx_word_clock_in};
            rxc_s_q    <= {rxc_s_q[0], rx_word_clock_in};
            txc_prev_q <= txc_s_q[1];
            rxc_prev_q <= rxc_s_q[1];
        end
    end

    // Transmit path: one word per transmit clock rising edge.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            tx_serial_word_out  <= 10'h000;
            tx_serial_valid_out <= 1'b0;
            rd_q                <= 1'b0;
        end else begin
            tx_serial_valid_out <= tx_rise;
            if (tx_rise && eight) begin
                tx_serial_word_out <= enc_code;
                rd_q               <= enc_rd;
            end else if (tx_rise) begin
                tx_serial_word_out <= tx_word_in;
            end
        end
    end

    // Receive path: hold the code group, launch on the selected event.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rx_hold_q            <= 10'h000;
            rx_parallel_word_out <= 10'h000;
            rec_clk_q            <= 1'b0;
        end else begin
            if (rx_code_valid_in) begin
                rx_hold_q <= rx_code_in;
                rec_clk_q <= ~rec_clk_q;
            end
            if (rx_launch) begin
                rx_parallel_word_out <= rx_sel;
            end
        end
    end

    // Violation flag stands for exactly one word.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            code_violation_flag_out <= 1'b0;
        end else begin
            code_violation_flag_out <= rx_launch & eight & dec_viol;
        end
    end

    assign rx_word_clock_out    = rec_clk_q;
    assign rx_word_clock_oe_out = ~read_mode;

    // Line status outputs.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            signal_loss_flag_out  <= 1'b0;
            rx_pll_unlocked_n_out <= 1'b1;
        end else begin
            signal_loss_flag_out  <= eight & ~rx_signal_present_in;
            rx_pll_unlocked_n_out <= ~rx_pll_locked_in;
        end
    end

    // System clock divider, stopped while the select input is high.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            div_q    <= 8'h00;
            sysclk_q <= 1'b0;
        end else if (operating_select_in) begin
            div_q    <= 8'h00;
            sysclk_q <= 1'b0;
        end else if (div_q == 8'(SYSCLK_HALF - 1)) begin
            div_q    <= 8'h00;
            sysclk_q <= ~sysclk_q;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // Differential pair of the system clock.
    assign system_clock_out_pos = sysclk_q;
    assign system_clock_out_neg = ~sysclk_q & ~operating_select_in;
endmodule : spw_word_port

// file: sim/spw_word_port_props.sv
`timescale 1ns/1ps
// Ties the outputs of the word port to their causes at its inputs.
module spw_word_port_props #(
    parameter int SYSCLK_HALF = 2
) (
    input wire logic       clk_sys_in,
    input wire logic       rst_in,
    input wire logic       link_idle_in,
    input wire logic       operating_select_in,
    input wire logic       tx_word_clock_in,
    input wire logic [9:0] tx_serial_word_out,
    input wire logic       tx_serial_valid_out,
    input wire logic       rx_pll_locked_in,
    input wire logic       rx_signal_present_in,
    input wire logic       rx_word_clock_oe_out,
    input wire logic       signal_loss_flag_out,
    input wire logic       rx_pll_unlocked_n_out,
    input wire logic       code_violation_flag_out,
    input wire logic       system_clock_out_pos,
    input wire logic       system_clock_out_neg
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic [3:0] since_q;  // Cycles since the transmit clock pin was seen rising.
    logic       tclk_q;   // Transmit clock pin one cycle ago.
    // Counts the cycles since the last rising edge of the transmit clock.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            since_q <= 4'hF;
            tclk_q  <= 1'b0;
        end else begin
            tclk_q  <= tx_word_clock_in;
            since_q <= (tx_word_clock_in && !tclk_q) ? 4'h0 : ((since_q == 4'hF) ? since_q : since_q + 4'h1);
        end
    end
    tx_cause_a: assert property (tx_serial_valid_out |-> since_q <= 4'h6)
        else $error("transmit word issued without a transmit clock edge");
    tx_pulse_a: assert property ($rose(tx_serial_valid_out) |=> $fell(tx_serial_valid_out))
        else $error("transmit valid is not a single cycle");
    tx_hold_a: assert property (!tx_serial_valid_out |-> $stable(tx_serial_word_out))
        else $error("transmit word changed without valid");
    viol_pulse_a: assert property (code_violation_flag_out |=> !code_violation_flag_out)
        else $error("violation flag longer than one cycle");
    lock_follow_a: assert property (!$past(rst_in) |-> rx_pll_unlocked_n_out == !$past(rx_pll_locked_in))
        else $error("lock status does not follow the receiver PLL");
    loss_cause_a: assert property (signal_loss_flag_out |-> !$past(rx_signal_present_in))
        else $error("loss flag raised while signal present");
    oe_idle_a: assert property ($changed(rx_word_clock_oe_out) |-> $past(link_idle_in) || $past(link_idle_in, 2))
        else $error("clock direction changed while link busy");
    sysclk_gate_a: assert property (operating_select_in && $past(operating_select_in) |-> !system_clock_out_neg && !system_clock_out_pos)
        else $error("system clock runs while select is high");
    sysclk_run_a: assert property (system_clock_out_pos && !operating_select_in |-> ##[1:8] !system_clock_out_pos)
        else $error("system clock stuck high");
    // Main scenarios reached by the bench.
    cover property ($rose(tx_serial_valid_out));
    cover property ($rose(code_violation_flag_out));
    cover property ($rose(signal_loss_flag_out));
endmodule : spw_word_port_props
bind spw_word_port spw_word_port_props #(.SYSCLK_HALF(SYSCLK_HALF)) u_props (.*);

// file: sim/spw_framer_model.sv
`timescale 1ns/1ps
// Framing controller: makes the word clocks and presents transmit words.
module spw_framer_model (
    input  wire logic       eight_bit_in,
    input  wire logic       read_clk_en_in,
    output logic            tx_word_clock_out,
    output logic      [9:0] tx_word_out,
    output logic            rx_word_clock_out
);
    // Transmit clock stands low until a word is sent; receive clock stands low until read_clk_en_in is set.
    initial begin
        tx_word_clock_out = 1'b0;
        tx_word_out       = 10'h155;
        rx_word_clock_out = 1'b0;
    end
    task automatic send(input logic [9:0] w);
        tx_word_out = eight_bit_in ? {1'b0, w[8:0]} : w;
        #62.5 tx_word_clock_out = 1'b1;
        #62.5 tx_word_clock_out = 1'b0;
        tx_word_out = ~tx_word_out;
    endtask : send
    always #62.5 if (read_clk_en_in) rx_word_clock_out = !rx_word_clock_out;
endmodule : spw_framer_model

// file: sim/spw_word_port_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; $display("Error %0t: got %h want %h", $time, a, e); end end
// Self-checking bench for the word port.
module spw_word_port_bench;
    logic clk_sys_in = 1'b0, rst_in = 1'b1, eight = 1'b0, dir = 1'b0, opsel = 1'b0, idle = 1'b0;
    logic [9:0] rx_code = 10'h000, exp_w;
    logic rx_valid = 1'b0, locked = 1'b0, present = 1'b1, rd_en = 1'b0, acc;
    wire tclk, rclk, rclk_o, oe, vld, loss, unl_n, viol, sp, sn;
    wire [9:0] tword, tx_o, rx_o;
    int seed = 72820, mismatches = 0, total_checks = 0, viol_seen = 0, n;
    logic [9:0] tx_exp[$];  // Transmit words still owed by the port.
    logic [9:0] owed_w;     // Oldest owed word, used only by the output watcher.
    initial forever #5 clk_sys_in = !clk_sys_in;
    spw_framer_model fm (.eight_bit_in(eight), .read_clk_en_in(rd_en), .tx_word_clock_out(tclk),
        .tx_word_out(tword), .rx_word_clock_out(rclk));
    spw_word_port dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .eight_bit_mode_in(eight),
        .rx_clock_direction_select_in(dir), .operating_select_in(opsel), .link_idle_in(idle),
        .tx_word_clock_in(tclk), .tx_word_in(tword), .tx_serial_word_out(tx_o), .tx_serial_valid_out(vld),
        .rx_code_in(rx_code), .rx_code_valid_in(rx_valid), .rx_pll_locked_in(locked),
        .rx_signal_present_in(present), .rx_word_clock_in(rclk), .rx_word_clock_out(rclk_o),
        .rx_word_clock_oe_out(oe), .rx_parallel_word_out(rx_o), .signal_loss_flag_out(loss),
        .rx_pll_unlocked_n_out(unl_n), .code_violation_flag_out(viol), .system_clock_out_pos(sp),
        .system_clock_out_neg(sn));
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic tick(input int k);
        repeat (k) @(negedge clk_sys_in);
    endtask : tick
    // Presents a code twice, two cycles apart, then leaves its inverse on the bus.
    task automatic send_code(input logic [9:0] c);
        repeat (2) begin
            tick(1);
            rx_code = c;
            rx_valid = 1'b1;
            tick(1);
            rx_valid = 1'b0;
        end
        rx_code = ~c;
        tick(2);
    endtask : send_code
    // Takes the oldest owed word whenever the port issues one.
    // Samples at the falling edge, where the registered outputs have settled.
    always @(negedge clk_sys_in) begin
        if (vld === 1'b1) begin
            owed_w = (tx_exp.size() == 0) ? ~tx_o : tx_exp.pop_front();
            `CHK(tx_o, owed_w)
        end
        if (viol === 1'b1) viol_seen++;
    end
    // Main sequence.
    initial begin
        tick(10);
        rst_in = 1'b0;
        `CHK(unl_n, 1'b1)
        `CHK(oe, 1'b1)
        locked = 1'b1;
        tick(3);
        `CHK(unl_n, 1'b0)
        for (int i = 0; i < 6; i++) begin
            exp_w = 10'($random(seed));
            tx_exp.push_back(exp_w);
            fm.send(exp_w);
        end
        for (n = 0; n < 50 && tx_exp.size() != 0; n++) tick(1);
        if (n == 50) begin
            mismatches++;
            close_out();
        end
        exp_w = 10'($random(seed));
        send_code(exp_w);
        `CHK(rx_o, exp_w)
        eight = 1'b1;
        present = 1'b0;
        tick(3);
        `CHK(loss, 1'b0)
        idle = 1'b1;
        tick(3);
        idle = 1'b0;
        tick(2);
        `CHK(loss, 1'b1)
        // Control character 0xBC from negative disparity; spare bit 9 is forced low by the model.
        tx_exp.push_back(10'h0FA);
        fm.send(10'h3BC);
        for (n = 0; n < 50 && tx_exp.size() != 0; n++) tick(1);
        if (n == 50) begin
            mismatches++;
            close_out();
        end
        send_code(10'h000);
        `CHK(viol_seen != 0, 1'b1)
        `CHK(rx_o[9], 1'b1)
        send_code(10'h0FA);
        `CHK(rx_o, 10'h1BC)
        present = 1'b1;
        tick(2);
        `CHK(loss, 1'b0)
        dir = 1'b1;
        rd_en = 1'b1;
        idle = 1'b1;
        tick(3);
        idle = 1'b0;
        tick(1);
        `CHK(oe, 1'b0)
        // Data byte 0x00 from negative disparity, launched by the read clock edges.
        send_code(10'h274);
        tick(10);
        `CHK(rx_o, 10'h000)
        opsel = 1'b1;
        tick(2);
        acc = 1'b0;
        repeat (8) begin
            tick(1);
            acc = acc | sn | sp;
        end
        `CHK(acc, 1'b0)
        opsel = 1'b0;
        acc = 1'b0;
        repeat (8) begin
            tick(1);
            acc = acc | sp;
        end
        `CHK(acc, 1'b1)
        close_out();
    end
endmodule : spw_word_port_bench
